// ---- src/retimer_drive_and_ctle_start_config.sv ----
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - Override set: start index from start register
// - Override clear: start index is zero
// - Index walks boost table upward from start
// - Swing code picks 0.6 V plus 0.1 V steps
// - De-emphasis code zero is 0 dB always
// - Range one selects the shallower dB set
// - Range zero selects the deeper dB set
// - Table byte holds four two-bit stage boosts
// - Channel reset bit restores table defaults
module retimer_drive_and_ctle_start_config
   import retimer_cfg_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       adapt_start,
   input  wire logic       fom_valid,
   input  wire logic [7:0] fom_value,
   output logic            fom_request,
   output logic            adapt_busy,
   output logic            adapt_done,
   output logic      [4:0] adapt_index,
   output logic      [4:0] best_index,
   output logic      [1:0] stage0_boost,
   output logic      [1:0] stage1_boost,
   output logic      [1:0] stage2_boost,
   output logic      [1:0] stage3_boost,
   output logic      [2:0] swing_code,
   output logic      [3:0] swing_x10,
   output logic      [2:0] deemph_code,
   output logic            deemph_range,
   output logic      [7:0] deemph_atten_x10
);
   import retimer_cfg_pkg::*;

   // Whole module state in one record
   typedef struct packed {
      logic [7:0]       chan_ctrl;     // Channel control, reset bit clears
      logic [7:0]       deemph;        // De-emphasis control
      logic [7:0]       swing;         // Output swing control
      logic [7:0]       ovr;           // Start override
      logic [7:0]       start_idx;     // Start index
      logic [31:0][7:0] table_live;    // Table that software sees
      logic [31:0][7:0] table_run;     // Snapshot used by the running scan
      adapt_state_t     state;         // Sequencer state
      logic [4:0]       idx;           // Entry under measurement
      logic [4:0]       best_idx;      // Best entry so far
      logic [7:0]       best_fom;      // Best figure of merit so far
      logic             best_ok;       // Best figure holds a real value
      logic             result_valid;  // A finished run left a result
      logic [7:0]       stage_word;    // Boost entry driven to the stages
      logic             done;          // One-cycle end of run
      logic [2:0]       swing_out;     // Registered swing code
      logic [3:0]       swing_x10_out; // Registered swing level
      logic [2:0]       dem_code_out;  // Registered de-emphasis code
      logic             dem_range_out; // Registered range bit
      logic [7:0]       dem_atten_out; // Registered attenuation
      logic [7:0]       rdata;         // Read data, valid one cycle
   } state_t;

   state_t st;       // Registered state
   state_t next_st;  // Next state

   logic [7:0] dem_atten;   // Decoded attenuation from the live register
   logic [4:0] tbl_sel;     // Table index from the bus address
   logic       tbl_hit;     // Bus address falls inside the table
   logic [4:0] run_start;   // Index where a new scan begins
   logic       new_best;    // Current figure beats the stored best
   logic [4:0] pick_idx;    // Best index including the current figure

   // Decoder shared with nothing else; kept apart so it can be reused
   deemphasis_decode u_deemph (
      .code      (st.deemph[2:0]),
      .range_sel (st.deemph[DEEMPH_RANGE_BIT]),
      .atten_x10 (dem_atten)
   );

   // Address decode for the boost table window
   assign tbl_hit = (reg_addr >= OFS_BOOST_TABLE_FIRST) &&
                    (reg_addr <= OFS_BOOST_TABLE_LAST);
   assign tbl_sel = reg_addr[4:0];

   // Start point of a scan, sampled only when a run begins
   assign run_start = st.ovr[START_OVERRIDE_BIT] ?
                      st.start_idx[4:0] :
                      DEFAULT_START_INDEX;

   // Best-so-far comparison for the figure arriving now
   assign new_best = !st.best_ok || (fom_value > st.best_fom);
   assign pick_idx = new_best ? st.idx : st.best_idx;

   // Next-state logic: bus, channel reset, sequencer, output decode
   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      next_st.rdata = 8'h00;

      // Register reads answer in the next cycle only
      if (reg_rd) begin
         if (tbl_hit) begin
            next_st.rdata = st.table_live[tbl_sel];
         end else begin
            case (reg_addr)
               OFS_CHANNEL_CONTROL      : next_st.rdata = st.chan_ctrl;
               OFS_DEEMPHASIS_CONTROL   : next_st.rdata = st.deemph;
               OFS_OUTPUT_SWING_CONTROL : next_st.rdata = st.swing;
               OFS_ADAPT_START_OVERRIDE : next_st.rdata = st.ovr;
               OFS_ADAPT_START_INDEX    : next_st.rdata = st.start_idx;
               OFS_ADAPT_STATUS : begin
                  // Busy, result valid and best entry of the last run
                  next_st.rdata[STATUS_BUSY_BIT]  =
                     (st.state == ADAPT_MEASURE);
                  next_st.rdata[STATUS_VALID_BIT] = st.result_valid;
                  next_st.rdata[4:0]              = st.best_idx;
               end
               default : next_st.rdata = 8'h00; // Unmapped reads zero
            endcase
         end
      end

      // Register writes; status and unmapped offsets are ignored
      if (reg_wr) begin
         if (tbl_hit) begin
            // Only the live copy moves; a running scan keeps its snapshot
            next_st.table_live[tbl_sel] = reg_wdata;
         end else begin
            case (reg_addr)
               OFS_CHANNEL_CONTROL : begin
                  if (reg_wdata[CHANNEL_RESET_BIT]) begin
                     // Channel reset: configuration back to defaults
                     next_st.table_live = BOOST_TABLE_DEFAULT;
                     next_st.deemph     = RESET_DEEMPHASIS_CONTROL;
                     next_st.swing      = RESET_OUTPUT_SWING_CONTROL;
                     next_st.ovr        = RESET_ADAPT_START_OVERRIDE;
                     next_st.start_idx  = RESET_ADAPT_START_INDEX;
                     next_st.chan_ctrl  = RESET_CHANNEL_CONTROL;
                  end else begin
                     next_st.chan_ctrl = reg_wdata;
                  end
                  // Reset bit is self-clearing and always reads zero
                  next_st.chan_ctrl[CHANNEL_RESET_BIT] = 1'b0;
               end
               OFS_DEEMPHASIS_CONTROL   : next_st.deemph    = reg_wdata;
               OFS_OUTPUT_SWING_CONTROL : next_st.swing     = reg_wdata;
               OFS_ADAPT_START_OVERRIDE : next_st.ovr       = reg_wdata;
               OFS_ADAPT_START_INDEX    : next_st.start_idx = reg_wdata;
               default : ;
            endcase
         end
      end

      // Adaptation sequencer
      case (st.state)
         ADAPT_IDLE : begin
            if (adapt_start) begin
               // Snapshot table and start point so later writes wait
               next_st.table_run  = st.table_live;
               next_st.idx        = run_start;
               next_st.stage_word = st.table_live[run_start];
               next_st.best_ok    = 1'b0;
               next_st.best_fom   = 8'h00;
               next_st.state      = ADAPT_MEASURE;
            end
         end
         ADAPT_MEASURE : begin
            if (fom_valid) begin
               if (new_best) begin
                  next_st.best_fom = fom_value;
                  next_st.best_idx = st.idx;
                  next_st.best_ok  = 1'b1;
               end
               if (st.idx == LAST_TABLE_INDEX) begin
                  // End of table: settle on the best entry seen
                  next_st.best_idx     = pick_idx;
                  next_st.stage_word   = st.table_run[pick_idx];
                  next_st.result_valid = 1'b1;
                  next_st.done         = 1'b1;
                  next_st.state        = ADAPT_IDLE;
               end else begin
                  // Step to the following entry of the snapshot
                  next_st.idx        = st.idx + 5'h01;
                  next_st.stage_word = st.table_run[st.idx + 5'h01];
               end
            end
         end
         default : next_st.state = ADAPT_IDLE;
      endcase

      // Driver settings follow the live registers one cycle later
      next_st.swing_out     = st.swing[2:0];
      next_st.swing_x10_out = SWING_BASE_X10 +
                              {1'b0, st.swing[2:0]};
      next_st.dem_code_out  = st.deemph[2:0];
      next_st.dem_range_out = st.deemph[DEEMPH_RANGE_BIT];
      next_st.dem_atten_out = dem_atten;
   end

   // State register; clock enable low freezes everything
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st               <= '0;
         st.chan_ctrl     <= RESET_CHANNEL_CONTROL;
         st.deemph        <= RESET_DEEMPHASIS_CONTROL;
         st.swing         <= RESET_OUTPUT_SWING_CONTROL;
         st.ovr           <= RESET_ADAPT_START_OVERRIDE;
         st.start_idx     <= RESET_ADAPT_START_INDEX;
         st.table_live    <= BOOST_TABLE_DEFAULT;
         st.table_run     <= BOOST_TABLE_DEFAULT;
         st.state         <= ADAPT_IDLE;
         st.swing_x10_out <= SWING_BASE_X10;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   // Handshake outputs straight from state
   assign fom_request = (st.state == ADAPT_MEASURE);
   assign adapt_busy  = (st.state == ADAPT_MEASURE);

   // Data outputs from flip-flops
   assign reg_rdata        = st.rdata;
   assign adapt_done       = st.done;
   assign adapt_index      = st.idx;
   assign best_index       = st.best_idx;
   assign stage0_boost     = st.stage_word[7:6];
   assign stage1_boost     = st.stage_word[5:4];
   assign stage2_boost     = st.stage_word[3:2];
   assign stage3_boost     = st.stage_word[1:0];
   assign swing_code       = st.swing_out;
   assign swing_x10        = st.swing_x10_out;
   assign deemph_code      = st.dem_code_out;
   assign deemph_range     = st.dem_range_out;
   assign deemph_atten_x10 = st.dem_atten_out;

endmodule

// ---- src/retimer_cfg_pkg.sv ----
package retimer_cfg_pkg;

   // Register offsets within one channel register set
   localparam logic [7:0] OFS_CHANNEL_CONTROL      = 8'h00;
   localparam logic [7:0] OFS_DEEMPHASIS_CONTROL   = 8'h15;
   localparam logic [7:0] OFS_OUTPUT_SWING_CONTROL = 8'h2d;
   localparam logic [7:0] OFS_ADAPT_START_OVERRIDE = 8'h2f;
   localparam logic [7:0] OFS_ADAPT_START_INDEX    = 8'h39;
   localparam logic [7:0] OFS_ADAPT_STATUS         = 8'h3b;
   localparam logic [7:0] OFS_BOOST_TABLE_FIRST    = 8'h40;
   localparam logic [7:0] OFS_BOOST_TABLE_LAST     = 8'h5f;

   // Field positions
   localparam int CHANNEL_RESET_BIT   = 2;
   localparam int START_OVERRIDE_BIT  = 3;
   localparam int DEEMPH_RANGE_BIT    = 6;
   localparam int STATUS_BUSY_BIT     = 7;
   localparam int STATUS_VALID_BIT    = 6;

   // Values after reset for the plain configuration registers
   localparam logic [7:0] RESET_CHANNEL_CONTROL      = 8'h00;
   localparam logic [7:0] RESET_DEEMPHASIS_CONTROL   = 8'h00;
   localparam logic [7:0] RESET_OUTPUT_SWING_CONTROL = 8'h00;
   localparam logic [7:0] RESET_ADAPT_START_OVERRIDE = 8'h00;
   localparam logic [7:0] RESET_ADAPT_START_INDEX    = 8'h00;

   // Start index used when the override is clear
   localparam logic [4:0] DEFAULT_START_INDEX = 5'h00;
   localparam logic [4:0] LAST_TABLE_INDEX    = 5'h1f;

   // Swing in tenths of a volt is this base plus the code
   localparam logic [3:0] SWING_BASE_X10 = 4'h6;

   // Default candidate boost table, entry 31 leftmost, entry 0 rightmost;
   // each byte holds stage 0 in 7:6 down to stage 3 in 1:0
   localparam logic [31:0][7:0] BOOST_TABLE_DEFAULT = {
      8'ha5, 8'h96, 8'h99, 8'hd5, 8'h75, 8'h69, 8'h5d, 8'h57,
      8'hc8, 8'hb0, 8'h8c, 8'h52, 8'h46, 8'ha0, 8'h82, 8'h88,
      8'h90, 8'h60, 8'hc0, 8'h50, 8'h41, 8'h30, 8'h0c, 8'h03,
      8'h80, 8'h02, 8'h08, 8'h40, 8'h10, 8'h04, 8'h01, 8'h00
   };

   // Adaptation sequencer states
   typedef enum logic [1:0] {
      ADAPT_IDLE    = 2'b00,
      ADAPT_MEASURE = 2'b01
   } adapt_state_t;

endpackage

// ---- src/deemphasis_decode.sv ----
`timescale 1ns/1ps
// Maps the de-emphasis code and range bit to an attenuation magnitude
// in tenths of a dB; the sign is always negative at the driver.
module deemphasis_decode (
   input  wire logic [2:0] code,
   input  wire logic       range_sel,
   output logic      [7:0] atten_x10
);

   // Pure table lookup, no state
   always_comb begin
      atten_x10 = 8'h00;
      case ({code, range_sel})
         4'b0000, 4'b0001 : atten_x10 = 8'h00;
         4'b0011 : atten_x10 = 8'h0f;
         4'b0101 : atten_x10 = 8'h23;
         4'b0111 : atten_x10 = 8'h32;
         4'b1001 : atten_x10 = 8'h41;
         4'b1011 : atten_x10 = 8'h50;
         4'b1101 : atten_x10 = 8'h5f;
         4'b1111 : atten_x10 = 8'h82;
         4'b0010 : atten_x10 = 8'h14;
         4'b0100 : atten_x10 = 8'h2a;
         4'b0110 : atten_x10 = 8'h3c;
         4'b1000 : atten_x10 = 8'h48;
         4'b1010 : atten_x10 = 8'h5a;
         4'b1100 : atten_x10 = 8'h6e;
         4'b1110 : atten_x10 = 8'h96;
         default : atten_x10 = 8'h00;
      endcase
   end

endmodule

// ---- test/retimer_cfg_checker_sva.sv ----
`timescale 1ns/1ps
// Port-level watch on the configuration block; sees ports only
module retimer_cfg_checker
   import retimer_cfg_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       reset_n,
   input wire logic       clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       adapt_start,
   input wire logic       fom_valid,
   input wire logic       adapt_busy,
   input wire logic       adapt_done,
   input wire logic [4:0] adapt_index,
   input wire logic [2:0] swing_code,
   input wire logic [3:0] swing_x10,
   input wire logic [2:0] deemph_code,
   input wire logic       deemph_range,
   input wire logic [7:0] deemph_atten_x10
);
   logic       ovr;  // Shadow of the start-override bit
   logic [4:0] sidx; // Shadow of the start index field
   // Magnitudes in tenths of a dB, range bit one and zero
   localparam logic [7:0] ATT1 [8] = '{8'h00, 8'h0f, 8'h23, 8'h32,
                                       8'h41, 8'h50, 8'h5f, 8'h82};
   localparam logic [7:0] ATT0 [8] = '{8'h00, 8'h14, 8'h2a, 8'h3c,
                                       8'h48, 8'h5a, 8'h6e, 8'h96};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Shadow follows writes, so the start check needs no register port
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ovr  <= 1'b0;
         sidx <= 5'h00;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == OFS_CHANNEL_CONTROL &&
             reg_wdata[CHANNEL_RESET_BIT]) begin
            ovr  <= 1'b0;
            sidx <= 5'h00;
         end
         if (reg_addr == OFS_ADAPT_START_OVERRIDE) begin
            ovr <= reg_wdata[START_OVERRIDE_BIT];
         end
         if (reg_addr == OFS_ADAPT_START_INDEX) begin
            sidx <= reg_wdata[4:0];
         end
      end
   end
   AST_SWING_LEVEL: assert property (swing_x10 == swing_code + 4'h6)
      else $error("swing level does not follow code");
   AST_DEEMPH_ZERO: assert property (deemph_code == 3'h0 |->
      deemph_atten_x10 == 8'h00) else $error("code zero not 0 dB");
   AST_DEEMPH_SHALLOW: assert property (deemph_range |->
      deemph_atten_x10 == ATT1[deemph_code]) else $error("range one dB");
   AST_DEEMPH_DEEP: assert property (!deemph_range |->
      deemph_atten_x10 == ATT0[deemph_code]) else $error("range zero dB");
   AST_START_OVERRIDE: assert property (clk_en && adapt_start &&
      !adapt_busy && ovr |=> adapt_busy && adapt_index == sidx)
      else $error("override start index wrong");
   AST_START_DEFAULT: assert property (clk_en && adapt_start &&
      !adapt_busy && !ovr |=> adapt_busy && adapt_index == 5'h00)
      else $error("default start index not zero");
   AST_INDEX_STEP: assert property (clk_en && adapt_busy && fom_valid &&
      adapt_index != LAST_TABLE_INDEX |=> adapt_busy &&
      adapt_index == $past(adapt_index) + 5'h01) else $error("bad step");
   AST_RUN_END: assert property (clk_en && adapt_busy && fom_valid &&
      adapt_index == LAST_TABLE_INDEX |=> adapt_done && !adapt_busy
      ##1 !adapt_done) else $error("run end wrong");
   AST_RESTART_IGNORED: assert property (clk_en && adapt_busy &&
      adapt_start && !fom_valid |=> adapt_busy && $stable(adapt_index))
      else $error("restart disturbed a run");
   AST_CHAN_RESET: assert property (clk_en && reg_wr &&
      reg_addr == OFS_CHANNEL_CONTROL && reg_wdata[CHANNEL_RESET_BIT]
      |=> ##1 swing_code == 3'h0 && deemph_code == 3'h0 && !deemph_range)
      else $error("channel reset left settings");
endmodule
bind retimer_drive_and_ctle_start_config retimer_cfg_checker i_chk (
   .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .adapt_start(adapt_start), .fom_valid(fom_valid),
   .adapt_busy(adapt_busy), .adapt_done(adapt_done),
   .adapt_index(adapt_index), .swing_code(swing_code),
   .swing_x10(swing_x10), .deemph_code(deemph_code),
   .deemph_range(deemph_range), .deemph_atten_x10(deemph_atten_x10));

// ---- test/retimer_drive_and_ctle_start_config_test.sv ----
`timescale 1ns/1ps
module retimer_drive_and_ctle_start_config_test;
   import retimer_cfg_pkg::*;
   logic        core_clk, reset_n, clk_en, reg_wr, reg_rd, adapt_start;
   logic        fom_valid, fom_request, adapt_busy, adapt_done, deemph_range;
   logic [7:0]  reg_addr, reg_wdata, fom_value, reg_rdata, deemph_atten_x10;
   logic [7:0]  d;
   logic [4:0]  adapt_index, best_index;
   logic [1:0]  stage0_boost, stage1_boost, stage2_boost, stage3_boost;
   logic [2:0]  swing_code, deemph_code;
   logic [3:0]  swing_x10;
   logic [31:0] xs = 32'hefd4;  // Random state, fixed seed
   int          err_total, samples_checked, cyc;
   int          mdl [256];      // Register model, unmapped stays zero
   int          snap [32];      // Table as it stood when a run began
   int t1 [8] = '{0, 15, 35, 50, 65, 80, 95, 130};
   int t0 [8] = '{0, 20, 42, 60, 72, 90, 110, 150};
   int al [8] = '{0, 'h15, 'h2d, 'h2f, 'h39, 'h3b, 'h40, 'h5f};
   retimer_drive_and_ctle_start_config i_dut (
      .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adapt_start(adapt_start),
      .fom_valid(fom_valid), .fom_value(fom_value),
      .fom_request(fom_request), .adapt_busy(adapt_busy),
      .adapt_done(adapt_done), .adapt_index(adapt_index),
      .best_index(best_index), .stage0_boost(stage0_boost),
      .stage1_boost(stage1_boost), .stage2_boost(stage2_boost),
      .stage3_boost(stage3_boost), .swing_code(swing_code),
      .swing_x10(swing_x10), .deemph_code(deemph_code),
      .deemph_range(deemph_range), .deemph_atten_x10(deemph_atten_x10));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // Cycle ceiling; the whole run needs about four hundred and twenty
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 6000) begin
         err_total++;
         stop_test();
      end
   end
   function logic [31:0] rnd();
      xs ^= xs << 13;
      xs ^= xs >> 17;
      xs ^= xs << 5;
      return xs;
   endfunction
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // Channel reset in the model: table defaults, settings cleared
   task mreset();
      foreach (al[k]) mdl[al[k]] = 0;
      for (int i = 0; i < 32; i++) mdl[64 + i] = BOOST_TABLE_DEFAULT[i];
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      if (a == 8'h00 && v[2]) mreset();
      else if (a inside {8'h00, 8'h15, 8'h2d, 8'h2f, 8'h39, [8'h40:8'h5f]})
         mdl[a] = (a == 8'h00) ? v & 8'hfb : v;
   endtask
   // Read data stands only in the cycle after the strobe
   task rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk("reg_rdata", reg_rdata, mdl[a]);
   endtask
   // One adaptation scan; a restart and a table write land mid-run
   task run();
      int st, best, bv, v;
      st = mdl['h2f][3] ? mdl['h39] & 31 : 0;
      for (int i = 0; i < 32; i++) snap[i] = mdl[64 + i];
      best = st;
      bv = -1;
      @(posedge core_clk) adapt_start <= 1'b1;
      @(posedge core_clk) adapt_start <= 1'b0;
      for (int i = st; i < 32; i++) begin
         @(negedge core_clk);
         chk("adapt_index", adapt_index, i);
         chk("busy", {fom_request, adapt_busy}, 3);
         chk("stages", {stage0_boost, stage1_boost, stage2_boost,
             stage3_boost}, snap[i]);
         v = rnd() & 255;
         if (v > bv) begin
            bv = v;
            best = i;
         end
         @(posedge core_clk);
         fom_valid <= 1'b1;
         fom_value <= v[7:0];
         adapt_start <= 1'b0;
         reg_wr <= 1'b0;
         @(posedge core_clk);
         fom_valid <= 1'b0;
         if (i == st) begin
            d = rnd();
            adapt_start <= 1'b1;
            reg_wr <= 1'b1;
            reg_addr <= 8'(65 + i);
            reg_wdata <= d;
            mdl[65 + i] = d;
         end
      end
      @(negedge core_clk);
      chk("done", {adapt_done, adapt_busy}, 2);
      chk("best_index", best_index, best);
      chk("best stages", {stage0_boost, stage1_boost, stage2_boost,
          stage3_boost}, snap[best]);
   endtask
   task stop_test();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      {reset_n, reg_wr, reg_rd, adapt_start, fom_valid} = 5'h00;
      {reg_addr, reg_wdata, fom_value} = 24'h000000;
      clk_en = 1'b1;
      mreset();
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      foreach (al[k]) rd(8'(al[k]));
      chk("swing_x10", swing_x10, 6);
      $display("test reset done");
      for (int c = 0; c < 8; c++) begin
         d = rnd();
         d[2:0] = c;
         wr(8'h2d, d);
         rd(8'h2d);
         chk("swing_code", swing_code, c);
         chk("swing_x10", swing_x10, 6 + c);
      end
      $display("test swing done");
      for (int k = 0; k < 16; k++) begin
         d = rnd();
         d[2:0] = k;
         d[6] = k / 8;
         wr(8'h15, d);
         rd(8'h15);
         chk("deemph_code", deemph_code, k % 8);
         chk("deemph_range", deemph_range, k / 8);
         if (d[2:0] == 0) chk("atten", deemph_atten_x10, 0);
         else if (d[6]) chk("atten", deemph_atten_x10, t1[d[2:0]]);
         else chk("atten", deemph_atten_x10, t0[d[2:0]]);
      end
      $display("test deemphasis done");
      for (int i = 0; i < 32; i++) wr(8'(64 + i), 8'(rnd()));
      for (int i = 0; i < 32; i++) rd(8'(64 + i));
      wr(8'h10, 8'h5a);
      rd(8'h10);
      wr(8'h3b, 8'hff);
      rd(8'h3b);
      $display("test table done");
      wr(8'h2f, 8'h00);
      run();
      $display("test default start done");
      wr(8'h39, 8'hfc);
      wr(8'h2f, 8'h08);
      run();
      $display("test override start done");
      wr(8'h00, 8'hff);
      for (int i = 0; i < 32; i++) rd(8'(64 + i));
      rd(8'h2d);
      chk("swing_code", swing_code, 0);
      $display("test channel reset done");
      // Clock enable low: a write must not land and outputs hold
      @(posedge core_clk) clk_en <= 1'b0;
      wr(8'h2d, 8'h07);
      mdl['h2d] = 0;
      clk_en <= 1'b1;
      rd(8'h2d);
      chk("frozen swing_code", swing_code, 0);
      chk("frozen swing_x10", swing_x10, 6);
      $display("test clock enable done");
      stop_test();
   end
endmodule
